// ===== hdl/can_ctl_status.sv
// Control register zero, prescaler, time stamp timer and sleep handling
//
// Contract
// (R1) Valid frame sets sticky flag; write one clears
// (R2) Loopback traffic ignored by receive status bits
// (R3) Receiver active bit read-only, from front end
// (R4) Stop in wait stops bus clocks
// (R5) Synchronized bit read-only, from controller
// (R6) Timer enable runs 16-bit bit-rate counter
// (R7) Write stamp to buffer after valid EOF
// (R8) Timer zero when off; enable low in init
// (R9) Wake-up enable restarts sleep on bus traffic
// (R10) Software sets wake-up enable before sleep
// (R11) Init mode holds register reset, three exceptions
// (R12) Writable outside init, except read-only bits
// (R13) Prescaler divides by field plus one
// (R14) Writes to read-only bits are ignored
`timescale 1ns/1ps
`include "can_ctl_defs.svh"

module can_ctl_status
   import can_ctl_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Protocol core, same clock
   input wire rx_report_t rx_report,
   input wire logic loopback,
   input wire logic wait_mode,
   // Bus receive pin, asynchronous
   input wire logic can_rx_pin,
   // Towards the core and clock control
   output stamp_t stamp,
   output logic bit_tick,
   output logic bus_clk_stop,
   output logic init_ack,
   output logic sleep_ack,
   output logic [7:0] bus_timing_one,
   output logic irq
);

////////////////////////////////////////////////////////////////////////////////
// Bus front end

logic wr_pend_q;
logic [7:0] addr_q;
logic [31:0] hrdata_q;
logic hreadyout_q;
logic hresp_q;
wire logic take = hsel && htrans[1] && hready;
wire logic [31:0] rd_data;

// Zero wait states; read data is latched at the address phase edge
always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
   end
   else
   begin
      wr_pend_q <= take && hwrite;
      addr_q <= take ? haddr : addr_q;
      hrdata_q <= (take && !hwrite) ? rd_data : 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
   end
end

assign hrdata = hrdata_q;
assign hreadyout = hreadyout_q;
assign hresp = hresp_q;

wire logic wr_ctl0 = wr_pend_q && (addr_q == `OFS_CTL0);
wire logic wr_btr0 = wr_pend_q && (addr_q == `OFS_BTR0);
wire logic wr_btr1 = wr_pend_q && (addr_q == `OFS_BTR1);
wire logic wr_irq_st = wr_pend_q && (addr_q == `OFS_IRQ_ST);
wire logic wr_irq_mask = wr_pend_q && (addr_q == `OFS_IRQ_MASK);

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser

logic rx_meta_q;
logic rx_sync_q;
logic rx_prev_q;

always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
   end
   else
   begin
      rx_meta_q <= can_rx_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
   end
end

// Dominant edge marks bus traffic
wire logic rx_fall = rx_prev_q && !rx_sync_q;

////////////////////////////////////////////////////////////////////////////////
// Control register zero

logic frame_flag_q;
logic rx_active_q;
logic stop_wait_q;
logic synced_q;
logic timer_en_q;
logic wakeup_en_q;
logic sleep_req_q;
logic init_req_q;
logic init_ack_q;
wire logic init_mode = init_req_q && init_ack_q;
wire logic wake_now;
wire logic set_frame = rx_report.frame_ok && !loopback; // (R1) (R2)
wire logic ctl_wr_ok = wr_ctl0 && !init_mode; // (R12)

// Software owned bits; all but the init request ignore writes while init mode is active
always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      stop_wait_q <= 1'b0;
      timer_en_q <= 1'b0;
      wakeup_en_q <= 1'b0;
      sleep_req_q <= 1'b0;
      init_req_q <= 1'b1;
      init_ack_q <= 1'b1;
   end
   else
   begin
      if (init_mode)
      begin
         stop_wait_q <= 1'b0; // (R11)
         timer_en_q <= 1'b0; // (R8)
      end
      else if (ctl_wr_ok)
      begin
         stop_wait_q <= hwdata[`CTL_SIW];
         timer_en_q <= hwdata[`CTL_TIM]; // (R6)
      end
      if (ctl_wr_ok)
      begin
         wakeup_en_q <= hwdata[`CTL_WUP];
      end
      if (wake_now)
      begin
         sleep_req_q <= 1'b0;
      end
      else if (ctl_wr_ok)
      begin
         sleep_req_q <= hwdata[`CTL_SLP];
      end
      if (wr_ctl0)
      begin
         init_req_q <= hwdata[`CTL_INI]; // (R12)
      end
      init_ack_q <= init_req_q;
   end
end

// Hardware owned bits; a software write can only clear the frame flag
always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      frame_flag_q <= 1'b0;
      rx_active_q <= 1'b0;
      synced_q <= 1'b0;
   end
   else if (init_mode)
   begin
      frame_flag_q <= 1'b0; // (R11)
      rx_active_q <= 1'b0;
      synced_q <= 1'b0;
   end
   else
   begin
      // A new frame wins over a clear in the same cycle
      frame_flag_q <= set_frame || (frame_flag_q && !(ctl_wr_ok && hwdata[`CTL_RXF])); // (R1)
      rx_active_q <= rx_report.active && !loopback; // (R3) (R2) (R14)
      synced_q <= rx_report.synced; // (R5) (R14)
   end
end

wire logic [7:0] ctl0_rd = {frame_flag_q, rx_active_q, stop_wait_q, synced_q,
                            timer_en_q, wakeup_en_q, sleep_req_q, init_req_q};

////////////////////////////////////////////////////////////////////////////////
// Bus timing registers

logic [7:0] btr0_q;
logic [7:0] btr1_q;

// Timing is only changed while the core is held in init mode
always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      btr0_q <= `RST_BTR0;
      btr1_q <= `RST_BTR1;
   end
   else
   begin
      if (wr_btr0 && init_mode)
      begin
         btr0_q <= {2'b00, hwdata[5:0]};
      end
      if (wr_btr1 && init_mode)
      begin
         btr1_q <= hwdata[7:0];
      end
   end
end

assign bus_timing_one = btr1_q;

////////////////////////////////////////////////////////////////////////////////
// Prescaler and bit clock

logic [5:0] presc_cnt_q;
logic [4:0] tq_cnt_q;
logic bit_tick_q;
wire logic [5:0] presc_max = btr0_q[5:0];
wire logic tq_tick = (presc_cnt_q == presc_max); // (R13)
// One sync quantum plus both time segments
wire logic [4:0] tq_max = 5'(btr1_q[3:0]) + 5'(btr1_q[6:4]) + 5'd2;

always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      presc_cnt_q <= 6'h00;
      tq_cnt_q <= 5'h00;
      bit_tick_q <= 1'b0;
   end
   else if (init_mode)
   begin
      presc_cnt_q <= 6'h00;
      tq_cnt_q <= 5'h00;
      bit_tick_q <= 1'b0;
   end
   else
   begin
      presc_cnt_q <= tq_tick ? 6'h00 : presc_cnt_q + 6'h01; // (R13)
      if (tq_tick)
      begin
         tq_cnt_q <= (tq_cnt_q == tq_max) ? 5'h00 : tq_cnt_q + 5'h01;
      end
      bit_tick_q <= tq_tick && (tq_cnt_q == tq_max);
   end
end

assign bit_tick = bit_tick_q;

////////////////////////////////////////////////////////////////////////////////
// Time stamp timer

logic [15:0] timer_q;
stamp_t stamp_q;

always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      timer_q <= 16'h0000;
      stamp_q <= '0;
   end
   else
   begin
      if (!timer_en_q)
      begin
         timer_q <= 16'h0000; // (R8)
      end
      else if (bit_tick_q)
      begin
         timer_q <= timer_q + 16'h0001; // (R6)
      end
      stamp_q.wr <= timer_en_q && rx_report.eof_valid; // (R7)
      stamp_q.hi_byte <= `STAMP_HI_BYTE;
      stamp_q.lo_byte <= `STAMP_LO_BYTE;
      stamp_q.value <= timer_q; // (R7)
   end
end

assign stamp = stamp_q;

////////////////////////////////////////////////////////////////////////////////
// Sleep, wake-up and wait mode

sleep_state_t state_q;
logic wakeup_latched_q;
logic bus_clk_stop_q;
wire logic in_sleep = (state_q == ST_SLEEP);
// The enable caught at sleep entry governs the whole sleep period
assign wake_now = in_sleep && wakeup_latched_q && rx_fall; // (R9) (R10)

always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      state_q <= ST_RUN;
      wakeup_latched_q <= 1'b0;
      bus_clk_stop_q <= 1'b0;
   end
   else
   begin
      unique case (state_q)
         ST_RUN:
         begin
            if (sleep_req_q && !rx_report.active && !init_mode)
            begin
               state_q <= ST_SLEEP;
               wakeup_latched_q <= wakeup_en_q; // (R10)
            end
         end
         ST_SLEEP:
         begin
            if (wake_now || !sleep_req_q)
            begin
               state_q <= ST_RUN; // (R9)
            end
         end
      endcase
      // Drives an external gate cell; this logic itself stays clocked
      bus_clk_stop_q <= stop_wait_q && wait_mode; // (R4)
   end
end

assign bus_clk_stop = bus_clk_stop_q;
assign init_ack = init_ack_q;
// One-hot code: the sleep bit of the state register is the flag itself
assign sleep_ack = state_q[1];

////////////////////////////////////////////////////////////////////////////////
// Interrupts

logic [1:0] irq_st_q;
logic [1:0] irq_mask_q;
logic irq_q;
wire logic [1:0] irq_set = {wake_now, set_frame};
wire logic [1:0] irq_clr = wr_irq_st ? hwdata[1:0] : 2'b00;

always_ff @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      irq_st_q <= `RST_IRQ;
      irq_mask_q <= `RST_IRQ;
      irq_q <= 1'b0;
   end
   else
   begin
      irq_st_q <= irq_set | (irq_st_q & ~irq_clr);
      if (wr_irq_mask)
      begin
         irq_mask_q <= hwdata[1:0];
      end
      irq_q <= |(irq_st_q & irq_mask_q);
   end
end

assign irq = irq_q;

////////////////////////////////////////////////////////////////////////////////
// Read selection

wire logic sel_ctl0 = (haddr == `OFS_CTL0);
wire logic sel_btr0 = (haddr == `OFS_BTR0);
wire logic sel_stat = (haddr == `OFS_STAT);
wire logic sel_btr1 = (haddr == `OFS_BTR1);
wire logic sel_ist = (haddr == `OFS_IRQ_ST);
wire logic sel_imask = (haddr == `OFS_IRQ_MASK);
wire logic sel_stamp = (haddr == `OFS_STAMP);
wire logic [7:0] stat_rd = {6'h00, in_sleep, init_ack_q};

// Unmapped addresses read zero
assign rd_data = sel_ctl0 ? {24'h00_0000, ctl0_rd} :
                 sel_btr0 ? {24'h00_0000, btr0_q} :
                 sel_stat ? {24'h00_0000, stat_rd} :
                 sel_btr1 ? {24'h00_0000, btr1_q} :
                 sel_ist ? {30'h0000_0000, irq_st_q} :
                 sel_imask ? {30'h0000_0000, irq_mask_q} :
                 sel_stamp ? {16'h0000, timer_q} :
                 32'h0000_0000;

endmodule // can_ctl_status

// ===== hdl/can_ctl_defs.svh
// Offsets, field positions, reset values and stamp byte positions of the control block
`ifndef CAN_CTL_DEFS_SVH
`define CAN_CTL_DEFS_SVH
// Register byte addresses, plus the word index of bus timing one
`define OFS_CTL0 8'h00
`define OFS_BTR0 8'h04
`define OFS_STAT 8'h08
`define IDX_BTR1 8'h03
`define OFS_BTR1 8'h0C
`define OFS_IRQ_ST 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_STAMP 8'h18
// Control register fields
`define CTL_RXF 7
`define CTL_RXA 6
`define CTL_SIW 5
`define CTL_SYN 4
`define CTL_TIM 3
`define CTL_WUP 2
`define CTL_SLP 1
`define CTL_INI 0
// Status and interrupt fields
`define STAT_INIT_ACK 0
`define STAT_SLEEP_ACK 1
`define IRQ_FRAME 0
`define IRQ_WAKE 1
// Reset values
`define RST_CTL0 8'h01
`define RST_BTR0 8'h00
`define RST_BTR1 8'h00
`define RST_IRQ 2'h0
// Stamp byte positions inside a message buffer
`define STAMP_HI_BYTE 8'h0E
`define STAMP_LO_BYTE 8'h0F
`endif

// ===== hdl/can_ctl_pkg.sv
// Types shared by the control and status block
package can_ctl_pkg;
   // Receiver front end report, same clock
   typedef struct packed {
      logic frame_ok;
      logic active;
      logic synced;
      logic eof_valid;
   } rx_report_t;
   // Time stamp towards the message buffer
   typedef struct packed {
      logic wr;
      logic [7:0] hi_byte;
      logic [7:0] lo_byte;
      logic [15:0] value;
   } stamp_t;
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_SLEEP = 2'b10
   } sleep_state_t;
endpackage

// ===== verif/can_ctl_status_asserts.sv
// Concurrent checks on the control and status block ports
`timescale 1ns/1ps
`include "can_ctl_defs.svh"
module can_ctl_status_asserts
   import can_ctl_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Register bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Core side
   input wire rx_report_t rx_report,
   input wire logic loopback,
   input wire logic wait_mode,
   input wire stamp_t stamp,
   input wire logic bit_tick,
   input wire logic bus_clk_stop,
   input wire logic init_ack
);
   default clocking dcb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Read of control zero outside init; inputs held steady so register lag is harmless
   wire logic rd_ctl = hsel & htrans[1] & hready & !hwrite & (haddr == `OFS_CTL0)
      & !init_ack & !loopback;
   property p_rx_active;
      rd_ctl && $stable({init_ack, loopback, rx_report}) |=>
         hrdata[`CTL_RXA] == $past(rx_report.active);
   endproperty
   a_rx_active: assert property (p_rx_active) else $error("receiver active bit wrong");
   property p_synced;
      rd_ctl && $stable({init_ack, loopback, rx_report}) |=>
         hrdata[`CTL_SYN] == $past(rx_report.synced);
   endproperty
   a_synced: assert property (p_synced) else $error("synchronized bit wrong");
   property p_stamp_cause;
      stamp.wr |-> $past(rx_report.eof_valid);
   endproperty
   a_stamp_cause: assert property (p_stamp_cause) else $error("stamp without frame end");
   property p_stamp_place;
      stamp.wr |-> stamp.hi_byte == `STAMP_HI_BYTE && stamp.lo_byte == `STAMP_LO_BYTE;
   endproperty
   a_stamp_place: assert property (p_stamp_place) else $error("stamp byte places wrong");
   property p_init_quiet;
      init_ack [*2] |-> !bit_tick;
   endproperty
   a_init_quiet: assert property (p_init_quiet) else $error("bit tick in init mode");
   property p_tick_gap;
      bit_tick |=> !bit_tick [*2];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("bit time too short");
   property p_clk_stop;
      !wait_mode |=> !bus_clk_stop;
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clock stop outside wait");
   property p_okay;
      hreadyout && !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or error");
endmodule // can_ctl_status_asserts

// ===== verif/can_bus_node.sv
// Behavioural bus node: receiver report and receive pin
`timescale 1ns/1ps
module can_bus_node
   import can_ctl_pkg::*;
(
   // Clock
   input wire logic hclk,
   // Towards the block
   output rx_report_t rx_report,
   output logic can_rx_pin
);
   initial
   begin
      rx_report = '0;
      can_rx_pin = 1'b1;
   end
   // Front end levels
   task set_state(input logic act, input logic syn);
      rx_report.active <= act;
      rx_report.synced <= syn;
   endtask
   // Valid end of frame; ok marks a received frame
   task end_frame(input logic ok);
      @(posedge hclk);
      rx_report.eof_valid <= 1'b1;
      rx_report.frame_ok <= ok;
      @(posedge hclk);
      rx_report.eof_valid <= 1'b0;
      rx_report.frame_ok <= 1'b0;
   endtask
   // Dominant bit, then recessive again as the bus idles high
   task dominant_pulse;
      @(posedge hclk);
      can_rx_pin <= 1'b0;
      repeat (8) @(posedge hclk);
      can_rx_pin <= 1'b1;
   endtask
endmodule // can_bus_node

// ===== verif/can_control_status_prescaler_tb_top.sv
// Bench: bus master tasks and register level scenarios
`timescale 1ns/1ps
module can_control_status_prescaler_tb_top
   import can_ctl_pkg::*;
   ;
   logic hclk, hresetn, hsel, hwrite, loopback, wait_mode, hreadyout, hresp;
   logic bit_tick, bus_clk_stop, init_ack, sleep_ack, irq, can_rx_pin;
   logic [7:0] haddr, bus_timing_one;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata;
   rx_report_t rx_report;
   stamp_t stamp;
   int miscompares, n_checks, cyc;
   logic [15:0] v1;
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   can_ctl_status uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx_report(rx_report), .loopback(loopback), .wait_mode(wait_mode),
      .can_rx_pin(can_rx_pin), .stamp(stamp), .bit_tick(bit_tick),
      .bus_clk_stop(bus_clk_stop), .init_ack(init_ack), .sleep_ack(sleep_ack),
      .bus_timing_one(bus_timing_one), .irq(irq));
   can_bus_node node (.hclk(hclk), .rx_report(rx_report), .can_rx_pin(can_rx_pin));
   ////////////////////////////////////////////////////////////////////////////////
   task ck(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One idle cycle first, so a read never sees a write still landing
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      ck(hrdata, e);
   endtask
   task period(input int e);
      int n;
      n = 0;
      @(posedge hclk iff bit_tick === 1'b1);
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (bit_tick !== 1'b1);
      ck(n, e);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // A hang costs a mismatch
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         close_out;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, loopback, wait_mode} = '0;
      {miscompares, n_checks, cyc} = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rd(8'h00, 32'h0000_0001);
      ck(init_ack, 1'b1);
      rd(8'h08, 32'h0000_0001);
      rd(8'h1C, 32'h0000_0000);
      wr(8'h04, 32'h0000_0000);
      wr(8'h0C, 32'h0000_0012);
      rd(8'h0C, 32'h0000_0012);
      ck(bus_timing_one, 32'h0000_0012);
      wr(8'h00, 32'h0000_0000);
      rd(8'h08, 32'h0000_0000);
      ck(init_ack, 1'b0);
      period(6);
      // Timing stays locked once init mode is left
      wr(8'h0C, 32'h0000_0077);
      rd(8'h0C, 32'h0000_0012);
      wr(8'h00, 32'h0000_0050);
      rd(8'h00, 32'h0000_0000);
      node.set_state(1'b1, 1'b1);
      rd(8'h00, 32'h0000_0050);
      loopback <= 1'b1;
      rd(8'h00, 32'h0000_0010);
      loopback <= 1'b0;
      wr(8'h14, 32'h0000_0003);
      node.end_frame(1'b1);
      rd(8'h00, 32'h0000_00D0);
      ck(irq, 1'b1);
      wr(8'h00, 32'h0000_0000);
      rd(8'h00, 32'h0000_00D0);
      wr(8'h00, 32'h0000_0080);
      rd(8'h00, 32'h0000_0050);
      wr(8'h10, 32'h0000_0001);
      rd(8'h10, 32'h0000_0000);
      ck(irq, 1'b0);
      loopback <= 1'b1;
      node.end_frame(1'b1);
      loopback <= 1'b0;
      rd(8'h00, 32'h0000_0050);
      node.set_state(1'b0, 1'b1);
      wr(8'h00, 32'h0000_0008);
      // Frame end placed two cycles after a tick, never on one
      @(posedge hclk iff bit_tick === 1'b1);
      node.end_frame(1'b0);
      @(posedge hclk);
      ck(stamp.wr, 1'b1);
      v1 = stamp.value;
      repeat (10) @(posedge hclk iff bit_tick === 1'b1);
      node.end_frame(1'b0);
      @(posedge hclk);
      ck(stamp.value, v1 + 16'h000A);
      wr(8'h00, 32'h0000_0000);
      rd(8'h18, 32'h0000_0000);
      wr(8'h00, 32'h0000_0020);
      wait_mode <= 1'b1;
      repeat (2) @(posedge hclk);
      ck(bus_clk_stop, 1'b1);
      wait_mode <= 1'b0;
      wr(8'h00, 32'h0000_000C);
      // Stop in wait cleared: wait mode must leave the clocks running
      wait_mode <= 1'b1;
      repeat (2) @(posedge hclk);
      ck(bus_clk_stop, 1'b0);
      wait_mode <= 1'b0;
      wr(8'h00, 32'h0000_000D);
      rd(8'h08, 32'h0000_0001);
      rd(8'h00, 32'h0000_0005);
      rd(8'h18, 32'h0000_0000);
      wr(8'h00, 32'h0000_003D);
      rd(8'h00, 32'h0000_0005);
      wr(8'h04, 32'h0000_003F);
      wr(8'h00, 32'h0000_0004);
      period(384);
      wr(8'h00, 32'h0000_0006);
      rd(8'h08, 32'h0000_0002);
      node.dominant_pulse;
      ck(sleep_ack, 1'b0);
      rd(8'h10, 32'h0000_0002);
      ck(irq, 1'b1);
      // Enable raised only after sleep entry must not wake this sleep period
      wr(8'h00, 32'h0000_0002);
      wr(8'h00, 32'h0000_0006);
      node.dominant_pulse;
      ck(sleep_ack, 1'b1);
      wr(8'h00, 32'h0000_0000);
      rd(8'h08, 32'h0000_0000);
      close_out;
   end
endmodule // can_control_status_prescaler_tb_top
bind can_ctl_status can_ctl_status_asserts chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .rx_report(rx_report), .loopback(loopback),
   .wait_mode(wait_mode), .stamp(stamp), .bit_tick(bit_tick), .bus_clk_stop(bus_clk_stop),
   .init_ack(init_ack));
